// *** common/dcmb_pkg.sv ***
/*
  Constants shared by the full-bridge motor control logic:
  register map, status layout and interval counts.
  Assumes a single 25 MHz clock; every interval is counted in its cycles.
*/
// Behaviour
// R1 - A high, B low drives output a high, b low; opposite pattern reverses.
// R2 - Sense trip while driving enters chopping; high side alternates, other stays low.
// R3 - Both inputs high drive both outputs low: braking while held.
// R4 - Both inputs low put both outputs in high impedance.
// R5 - Both inputs low beyond 1 ms enter low-power standby.
// R6 - Controller waits up to 30 us after standby exit before drive commands.
// R7 - Each PWM cycle enables a diagonal pair; a trip turns it off.
// R8 - After each trip the bridge stays off a fixed time, then conducts.
// R9 - Off-time is fast decay for its first half, slow decay after.
// R10 - Fast-to-slow change forces all drivers off for the dead time.
// R11 - No synchronous rectification during the dead time.
// R12 - Rectify during decay; stop when load current reaches zero.
// R13 - Short or overcurrent latches a fault and disables all outputs.
// R14 - The fault clears only on standby exit or supply power cycle.
// R15 - Over-temperature disables outputs until the indication clears.
// R16 - Supply undervoltage holds all drivers off.
// R17 - Sense comparator ignored during blanking after each turn-on; code blanks only on drive entry, not when hot, low supply or disable lifts.
// R18 - Off, blank, dead and standby intervals are parameterised counters.
package dcmb_pkg;

  // ----------------------------------------
  // clock and intervals
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 40000;
  localparam int OFF_TIME_NS = 25000;
  localparam int BLANK_TIME_NS = 3000;
  localparam int DEAD_TIME_NS = 50;
  localparam int STANDBY_TIME_NS = 1000000;
  // off, blank and dead times round up, none below one cycle; standby truncates
  localparam int OFF_CYC = (OFF_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BLANK_CYC = (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DEAD_CYC = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STANDBY_CYC = (STANDBY_TIME_NS / 1000) * (1000000 / CLK_PERIOD_PS);
  localparam int FAST_PCT = 50;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] CTRL_ADDR = 8'h00;
  localparam logic [APB_AW-1:0] STATUS_ADDR = 8'h04;
  localparam logic CTRL_ENABLE_RST = 1'h1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int ST_W = 7;
  localparam int STAT_W = 12;
  // status fields: state one-hot in [6:0], then flags
  localparam int STAT_FAULT_BIT = 7;
  localparam int STAT_STBY_BIT = 8;
  localparam int STAT_HOT_BIT = 9;
  localparam int STAT_LOW_BIT = 10;
  localparam int STAT_FWD_BIT = 11;

  typedef enum logic [ST_W-1:0] {
    ST_COAST = 7'h01,
    ST_DRIVE = 7'h02,
    ST_FAST = 7'h04,
    ST_DEAD = 7'h08,
    ST_SLOW = 7'h10,
    ST_BRAKE = 7'h20,
    ST_STBY = 7'h40
  } dcmb_state_type;

endpackage

// *** common/dcmb_reg_if.sv ***
/*
  Carrier between the register slave and the bridge core.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface dcmb_reg_if;
  logic ctrl_enable;
  logic [dcmb_pkg::STAT_W-1:0] status;
  modport regs (output ctrl_enable, input status);
  modport core (input ctrl_enable, output status);
endinterface

// *** hw/dcmb_apb.sv ***
/*
  APB slave for the control and status registers.
  Assumes a standard APB master; answers with zero wait states,
  pready registered, error on unmapped addresses.
*/
`timescale 1ns/1ps
module dcmb_apb (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // write
  input wire logic [dcmb_pkg::APB_AW-1:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // ready
  output logic pslverr, // unmapped address
  dcmb_reg_if.regs rif // toward the core
);
  import dcmb_pkg::*;

  logic en_q, en_d, rdy_q, rdy_d, err_q, err_d;
  logic [31:0] rd_q, rd_d;
  logic mapped;

  always_comb
  begin
    mapped = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR);
    rdy_d = psel && !penable;
    err_d = psel && !penable && !mapped;
    rd_d = rd_q;
    if (psel && !penable)
    begin
      rd_d = 32'h0000_0000;
      if (paddr == CTRL_ADDR)
        rd_d[CTRL_ENABLE_BIT] = en_q;
      else if (paddr == STATUS_ADDR)
        rd_d[STAT_W-1:0] = rif.status;
    end
    en_d = en_q;
    // write lands only at the completing edge
    if (psel && penable && rdy_q && pwrite && paddr == CTRL_ADDR)
      en_d = pwdata[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= CTRL_ENABLE_RST;
      rdy_q <= 1'h0;
      err_q <= 1'h0;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      en_q <= en_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      rd_q <= rd_d;
    end
  end

  assign rif.ctrl_enable = en_q;
  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
endmodule

// *** hw/dcmb_sync.sv ***
/*
  Three-stage synchroniser for pin inputs.
  Assumes inputs are asynchronous to pclk; a change is taken once
  stages two and three agree.
*/
`timescale 1ns/1ps
module dcmb_sync #(
  parameter int W = 1
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic [W-1:0] pin_in, // raw pins
  output logic [W-1:0] sync_out // filtered levels
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // bit follows stage two only where stages agree
  always_comb
  begin
    out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule

// *** hw/dcmb_top.sv ***
/*
  Full-bridge DC motor control core: input decode, fixed off-time
  mixed-decay chopping, dead time, synchronous rectification, standby
  timer and protection gating, with an APB register slave.
  Assumes the comparators (sense trip, zero current, overcurrent,
  over-temperature with its own hysteresis, undervoltage) arrive as
  asynchronous logic levels, and that the gate driver turns each
  half-bridge high-side/low-side enable into the bridge pin state.
*/
`timescale 1ns/1ps
module dcmb_top #(
  parameter int OFF_CYCLES = dcmb_pkg::OFF_CYC,
  parameter int BLANK_CYCLES = dcmb_pkg::BLANK_CYC,
  parameter int DEAD_CYCLES = dcmb_pkg::DEAD_CYC,
  parameter int STANDBY_CYCLES = dcmb_pkg::STANDBY_CYC
) (
  input wire logic pclk, // 25 MHz clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [dcmb_pkg::APB_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic drive_input_a, // direction input a
  input wire logic drive_input_b, // direction input b
  input wire logic sense_trip, // ten times sense above reference
  input wire logic zero_current, // load current at zero
  input wire logic short_detect, // output short or overcurrent
  input wire logic over_temp, // thermal indication, hysteretic
  input wire logic supply_low_lockout, // load supply undervoltage
  output logic bridge_output_a_hs, // half-bridge a high side on
  output logic bridge_output_a_ls, // half-bridge a low side on
  output logic bridge_output_b_hs, // half-bridge b high side on
  output logic bridge_output_b_ls, // half-bridge b low side on
  output logic overcurrent_fault, // latched short fault
  output logic standby // low-power standby active
);
  import dcmb_pkg::*;

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pins_raw, pins;
  logic in_a, in_b, trip, zero_i, short_i, hot, low_v;

  assign pins_raw = {supply_low_lockout, over_temp, short_detect,
                     zero_current, sense_trip, drive_input_b, drive_input_a};

  dcmb_sync #(.W(NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pins_raw),
    .sync_out(pins)
  );

  assign in_a = pins[0];
  assign in_b = pins[1];
  assign trip = pins[2];
  assign zero_i = pins[3];
  assign short_i = pins[4];
  assign hot = pins[5];
  assign low_v = pins[6];

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  dcmb_reg_if rif ();

  dcmb_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif.regs)
  );

  // ----------------------------------------
  // state and counters
  // ----------------------------------------
  dcmb_state_type state_q, state_d;
  logic fwd_q, fwd_d;
  logic fault_q, fault_d;
  logic sr_q, sr_d;
  logic [CNT_W-1:0] off_q, off_d;
  logic [CNT_W-1:0] blank_q, blank_d;
  logic [CNT_W-1:0] dead_q, dead_d;
  logic [CNT_W-1:0] stby_q, stby_d;
  logic run_ok;
  logic both_low, both_high, one_hot_in;
  logic blank_done, fast_done, off_done, dead_done, stby_done;

  localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFF_CYCLES - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'((OFF_CYCLES * FAST_PCT) / 100 - 1);
  localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYCLES - 1);
  localparam logic [CNT_W-1:0] DEAD_LAST = CNT_W'(DEAD_CYCLES - 1);
  localparam logic [CNT_W-1:0] STBY_LAST = CNT_W'(STANDBY_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // saturating up-count used by every interval timer
  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c,
                                               input logic [CNT_W-1:0] last);
    count_up = (c == last) ? c : c + CNT_ONE;
  endfunction

  always_comb
  begin
    both_low = !in_a && !in_b;
    both_high = in_a && in_b;
    one_hot_in = in_a ^ in_b;
    blank_done = (blank_q == BLANK_LAST); // R17
    fast_done = (off_q == FAST_LAST); // R9
    off_done = (off_q == OFF_LAST); // R8
    dead_done = (dead_q == DEAD_LAST); // R10
    stby_done = (stby_q == STBY_LAST); // R5 R18
    // any protection or software disable removes all drive
    run_ok = !fault_q && !hot && !low_v && rif.ctrl_enable; // R15 R16
  end

  // ----------------------------------------
  // bridge sequencer
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    fwd_d = fwd_q;
    off_d = off_q;
    blank_d = blank_q;
    dead_d = dead_q;
    stby_d = both_low ? count_up(stby_q, STBY_LAST) : '0;
    sr_d = sr_q;
    case (state_q)
      ST_COAST:
      begin
        if (both_low && stby_done)
          state_d = ST_STBY; // R5
        else if (both_high)
          state_d = ST_BRAKE; // R3
        else if (one_hot_in)
        begin
          state_d = ST_DRIVE; // R1
          fwd_d = in_a;
          blank_d = '0;
        end
      end
      ST_DRIVE:
      begin
        blank_d = count_up(blank_q, BLANK_LAST);
        if (!one_hot_in || in_a != fwd_q)
        begin
          state_d = ST_COAST;
        end
        else if (blank_done && trip)
        begin
          // latch reset: diagonal pair off, fast decay begins
          state_d = ST_FAST; // R2 R7
          off_d = '0;
          sr_d = 1'h1;
        end
      end
      ST_FAST:
      begin
        off_d = count_up(off_q, OFF_LAST);
        if (zero_i)
          sr_d = 1'h0; // R12
        if (!one_hot_in || in_a != fwd_q)
          state_d = ST_COAST;
        else if (fast_done)
        begin
          state_d = ST_DEAD; // R10
          dead_d = '0;
        end
      end
      ST_DEAD:
      begin
        off_d = count_up(off_q, OFF_LAST);
        dead_d = count_up(dead_q, DEAD_LAST);
        if (!one_hot_in || in_a != fwd_q)
          state_d = ST_COAST;
        else if (dead_done)
        begin
          state_d = ST_SLOW;
          sr_d = !zero_i; // R12
        end
      end
      ST_SLOW:
      begin
        off_d = count_up(off_q, OFF_LAST);
        if (zero_i)
          sr_d = 1'h0; // R12
        if (!one_hot_in || in_a != fwd_q)
          state_d = ST_COAST;
        else if (off_done)
        begin
          // next PWM cycle: diagonal back on, blanking restarts
          state_d = ST_DRIVE; // R7 R8
          blank_d = '0;
        end
      end
      ST_BRAKE:
      begin
        if (!both_high)
          state_d = ST_COAST; // R3
      end
      ST_STBY:
      begin
        if (!both_low)
          state_d = ST_COAST; // R14
      end
      default:
      begin
        state_d = ST_COAST;
      end
    endcase
  end

  // ----------------------------------------
  // overcurrent latch
  // ----------------------------------------
  always_comb
  begin
    fault_d = fault_q;
    // shorts are ignored in standby, so the exit clear never meets a set in its cycle
    if (state_q == ST_STBY && state_d != ST_STBY)
      fault_d = 1'h0; // R14
    if (short_i && state_q != ST_STBY)
      fault_d = 1'h1; // R13
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_COAST;
      fwd_q <= 1'h1;
      fault_q <= 1'h0;
      sr_q <= 1'h0;
      off_q <= '0;
      blank_q <= '0;
      dead_q <= '0;
      stby_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      fwd_q <= fwd_d;
      fault_q <= fault_d;
      sr_q <= sr_d;
      off_q <= off_d;
      blank_q <= blank_d;
      dead_q <= dead_d;
      stby_q <= stby_d;
    end
  end

  // ----------------------------------------
  // gate decode
  // ----------------------------------------
  // gates follow the next state so they move with the sequencer edge;
  // the output register adds no cycle of delay yet gives glitch-free driver inputs
  logic [3:0] gate_q, gate_d; // {a_hs, a_ls, b_hs, b_ls}
  logic stby_out_q, stby_out_d;

  always_comb
  begin
    gate_d = 4'h0;
    case (state_d)
      ST_DRIVE:
        gate_d = fwd_d ? 4'h9 : 4'h6; // R1 R7
      ST_FAST:
        // opposite diagonal carries recirculation while current flows
        gate_d = !sr_d ? 4'h0 : (fwd_d ? 4'h6 : 4'h9); // R9 R12
      ST_DEAD:
        gate_d = 4'h0; // R10 R11
      ST_SLOW:
        // both low sides short the winding; the driven side stays low
        gate_d = sr_d ? 4'h5 : (fwd_d ? 4'h1 : 4'h4); // R2 R9 R12
      ST_BRAKE:
        gate_d = 4'h5; // R3
      default:
        gate_d = 4'h0; // R4
    endcase
    if (!run_ok || fault_d)
      gate_d = 4'h0; // R13 R15 R16
    stby_out_d = (state_d == ST_STBY); // R5
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_q <= 4'h0;
      stby_out_q <= 1'h0;
    end
    else
    begin
      gate_q <= gate_d;
      stby_out_q <= stby_out_d;
    end
  end

  assign bridge_output_a_hs = gate_q[3];
  assign bridge_output_a_ls = gate_q[2];
  assign bridge_output_b_hs = gate_q[1];
  assign bridge_output_b_ls = gate_q[0];
  assign overcurrent_fault = fault_q;
  assign standby = stby_out_q;

  // ----------------------------------------
  // status toward software
  // ----------------------------------------
  always_comb
  begin
    rif.status = '0;
    rif.status[ST_W-1:0] = state_q;
    rif.status[STAT_FAULT_BIT] = fault_q;
    rif.status[STAT_STBY_BIT] = stby_out_q;
    rif.status[STAT_HOT_BIT] = hot;
    rif.status[STAT_LOW_BIT] = low_v;
    rif.status[STAT_FWD_BIT] = fwd_q;
  end

endmodule

// *** test/dcmb_ctl_model.sv ***
/*
  Controller model on the far side of the two direction inputs.
  Assumes the bench posts the wanted input pair on req_a and req_b.
*/
`timescale 1ns/1ps
module dcmb_ctl_model #(
  parameter int WAKE_CYCLES = 750
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic standby, // device asleep
  input wire logic req_a, // wanted a
  input wire logic req_b, // wanted b
  output logic drive_input_a, // to device
  output logic drive_input_b, // to device
  output logic ready // request applied
);
  int hold_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_input_a <= 1'h0;
      drive_input_b <= 1'h0;
      hold_q <= 0;
    end
    else if (hold_q != 0)
      hold_q <= hold_q - 1;
    else if ({req_a, req_b} != {drive_input_a, drive_input_b})
    begin
      drive_input_a <= req_a;
      drive_input_b <= req_b;
      // wake command, then 30 us at 25 MHz for the charge pump
      if (standby && (req_a || req_b))
        hold_q <= WAKE_CYCLES;
    end
  end
  assign ready = (hold_q == 0) && ({req_a, req_b} == {drive_input_a, drive_input_b});
endmodule

// *** test/dcmb_top_props.sv ***
/*
  Checker for the bridge control top: gate safety, decode and protection.
  Assumes it is bound to dcmb_top and sees only its ports.
*/
`timescale 1ns/1ps
module dcmb_top_props #(
  parameter int OFF_CYCLES = dcmb_pkg::OFF_CYC,
  parameter int BLANK_CYCLES = dcmb_pkg::BLANK_CYC,
  parameter int DEAD_CYCLES = dcmb_pkg::DEAD_CYC,
  parameter int STANDBY_CYCLES = dcmb_pkg::STANDBY_CYC
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic drive_input_a, // input a
  input wire logic drive_input_b, // input b
  input wire logic short_detect, // short
  input wire logic over_temp, // hot
  input wire logic supply_low_lockout, // supply_low_lockout
  input wire logic bridge_output_a_hs, // gate
  input wire logic bridge_output_a_ls, // gate
  input wire logic bridge_output_b_hs, // gate
  input wire logic bridge_output_b_ls, // gate
  input wire logic overcurrent_fault, // fault
  input wire logic standby // standby
);
  logic [3:0] g;
  logic off, fwd, calm, stby_d1, stby_d2;
  assign g = {bridge_output_a_hs, bridge_output_a_ls, bridge_output_b_hs, bridge_output_b_ls};
  assign off = (g == 4'h0);
  assign fwd = (g == 4'h9);
  assign calm = !over_temp && !supply_low_lockout && !short_detect && !overcurrent_fault;
  // ----------------------------------------
  // standby history for the fault clear
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stby_d1 <= 1'h0;
      stby_d2 <= 1'h0;
    end
    else
    begin
      stby_d1 <= standby;
      stby_d2 <= stby_d1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  // margin of six covers the pin synchroniser and the state register
  sequence s_coast;
    (!drive_input_a && !drive_input_b)[*6];
  endsequence
  sequence s_brake;
    (drive_input_a && drive_input_b && calm)[*8];
  endsequence
  sequence s_hot;
    over_temp[*6];
  endsequence
  AST_NO_SHOOT: assert property (!(g[3] && g[2]) && !(g[1] && g[0]))
    else $error("half-bridge shoot-through");
  AST_DEAD: assert property ($rose(g == 4'h5) |-> $past(off, 1) && $past(off, DEAD_CYCLES))
    else $error("slow decay entered without dead time");
  AST_BLANK: assert property ($rose(fwd) && calm |-> fwd[*4])
    else $error("drive cut inside blanking");
  AST_COAST: assert property (s_coast |-> off)
    else $error("coast not high impedance");
  AST_BRAKE: assert property (s_brake |-> g == 4'h5)
    else $error("brake not both low");
  AST_STBY_OFF: assert property (standby |-> off)
    else $error("gates on in standby");
  AST_SUPPLY_LOW_LOCKOUT_OFF: assert property (supply_low_lockout[*6] |-> off)
    else $error("gates on under lockout");
  AST_HOT_OFF: assert property (s_hot |-> off)
    else $error("gates on while hot");
  AST_FAULT_SET: assert property ((short_detect && !standby)[*7] |-> overcurrent_fault)
    else $error("short not latched");
  AST_FAULT_OFF: assert property (overcurrent_fault[*2] |-> off)
    else $error("gates on with fault");
  AST_FAULT_HOLD: assert property ($fell(overcurrent_fault) |-> stby_d1 || stby_d2)
    else $error("fault cleared outside standby exit");
endmodule

bind dcmb_top dcmb_top_props #(
  .OFF_CYCLES(OFF_CYCLES),
  .BLANK_CYCLES(BLANK_CYCLES),
  .DEAD_CYCLES(DEAD_CYCLES),
  .STANDBY_CYCLES(STANDBY_CYCLES)
) u_props (
  .pclk(pclk),
  .presetn(presetn),
  .drive_input_a(drive_input_a),
  .drive_input_b(drive_input_b),
  .short_detect(short_detect),
  .over_temp(over_temp),
  .supply_low_lockout(supply_low_lockout),
  .bridge_output_a_hs(bridge_output_a_hs),
  .bridge_output_a_ls(bridge_output_a_ls),
  .bridge_output_b_hs(bridge_output_b_hs),
  .bridge_output_b_ls(bridge_output_b_ls),
  .overcurrent_fault(overcurrent_fault),
  .standby(standby)
);

// *** test/tb_top.sv ***
/*
  Self-checking bench for the bridge control top.
  Assumes shortened interval parameters and the controller model.
*/
`timescale 1ns/1ps
module tb_top;
  import dcmb_pkg::*;
  localparam int OFF = 20;
  localparam int BLANK = 4;
  localparam int DEAD = 2;
  localparam int STBY = 50;
  localparam int FAST = OFF * FAST_PCT / 100;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic req_a = 1'h0;
  logic req_b = 1'h0;
  logic sense_trip = 1'h0;
  logic zero_current = 1'h0;
  logic short_detect = 1'h0;
  logic over_temp = 1'h0;
  logic supply_low_lockout = 1'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, in_a, in_b, a_hs, a_ls, b_hs, b_ls, fault, standby, ready;
  logic [6:0] obs;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  assign obs = {ready, standby, fault, a_hs, a_ls, b_hs, b_ls};
  always #20 pclk = ~pclk;
  dcmb_ctl_model u_ctl (.pclk(pclk), .presetn(presetn), .standby(standby), .req_a(req_a),
    .req_b(req_b), .drive_input_a(in_a), .drive_input_b(in_b), .ready(ready));
  dcmb_top #(.OFF_CYCLES(OFF), .BLANK_CYCLES(BLANK), .DEAD_CYCLES(DEAD), .STANDBY_CYCLES(STBY))
  dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_input_a(in_a), .drive_input_b(in_b), .sense_trip(sense_trip),
    .zero_current(zero_current), .short_detect(short_detect), .over_temp(over_temp),
    .supply_low_lockout(supply_low_lockout), .bridge_output_a_hs(a_hs),
    .bridge_output_a_ls(a_ls), .bridge_output_b_hs(b_hs), .bridge_output_b_ls(b_ls),
    .overcurrent_fault(fault), .standby(standby));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic limit(input int i);
    if (i > 2000)
    begin
      miscompares++;
      finish_test();
    end
  endtask
  // outputs read just after an edge still hold the values sampled at it
  task automatic wait_obs(input logic [6:0] mask, input logic [6:0] val);
    int i;
    i = 0;
    while ((obs & mask) !== val)
    begin
      @(posedge pclk);
      i++;
      limit(i);
    end
    samples_checked++;
  endtask
  task automatic phase_len(input logic [3:0] pat);
    n = 0;
    while (obs[3:0] === pat)
    begin
      @(posedge pclk);
      n++;
      limit(n);
    end
  endtask
  task automatic go(input logic a, input logic b);
    @(posedge pclk);
    req_a <= a;
    req_b <= b;
  endtask
  task automatic apb(input logic wr, input logic [APB_AW-1:0] addr, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    i = 0;
    while (pready !== 1'h1)
    begin
      @(posedge pclk);
      i++;
      limit(i);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL_ADDR, '0);
    check(rd, 32'h1);
    apb(1'h1, STATUS_ADDR, 32'hFFF);
    apb(1'h0, STATUS_ADDR, '0);
    check(rd, 32'h801);
    apb(1'h0, 8'h08, '0);
    check({err, rd[30:0]}, 32'h80000000);
    go(1'h1, 1'h0);
    wait_obs(7'h0F, 7'h09);
    apb(1'h0, STATUS_ADDR, '0);
    check(rd, 32'h802);
    sense_trip <= 1'h1;
    wait_obs(7'h0F, 7'h06);
    sense_trip <= 1'h0;
    phase_len(4'h6);
    check(n, FAST);
    phase_len(4'h0);
    check(n, DEAD);
    phase_len(4'h5);
    check(n, OFF - FAST - DEAD);
    check(32'(obs[3:0]), 32'h9);
    sense_trip <= 1'h1;
    wait_obs(7'h0F, 7'h06);
    sense_trip <= 1'h0;
    zero_current <= 1'h1;
    wait_obs(7'h0F, 7'h01);
    wait_obs(7'h0F, 7'h09);
    zero_current <= 1'h0;
    go(1'h0, 1'h0);
    wait_obs(7'h0F, 7'h00);
    sense_trip <= 1'h1;
    go(1'h1, 1'h0);
    wait_obs(7'h0F, 7'h09);
    phase_len(4'h9);
    check(32'(n >= BLANK), 32'h1);
    sense_trip <= 1'h0;
    wait_obs(7'h0F, 7'h09);
    go(1'h0, 1'h0);
    wait_obs(7'h0F, 7'h00);
    go(1'h0, 1'h1);
    wait_obs(7'h0F, 7'h06);
    go(1'h0, 1'h0);
    wait_obs(7'h0F, 7'h00);
    go(1'h1, 1'h1);
    wait_obs(7'h0F, 7'h05);
    repeat (20) @(posedge pclk);
    check(32'(obs[3:0]), 32'h5);
    go(1'h0, 1'h0);
    wait_obs(7'h0F, 7'h00);
    go(1'h1, 1'h0);
    wait_obs(7'h0F, 7'h09);
    supply_low_lockout <= 1'h1;
    wait_obs(7'h0F, 7'h00);
    supply_low_lockout <= 1'h0;
    wait_obs(7'h0F, 7'h09);
    over_temp <= 1'h1;
    wait_obs(7'h0F, 7'h00);
    repeat (20) @(posedge pclk);
    check(32'(obs[3:0]), 32'h0);
    over_temp <= 1'h0;
    wait_obs(7'h0F, 7'h09);
    apb(1'h1, CTRL_ADDR, '0);
    wait_obs(7'h0F, 7'h00);
    apb(1'h1, CTRL_ADDR, 32'h1);
    wait_obs(7'h0F, 7'h09);
    short_detect <= 1'h1;
    wait_obs(7'h3F, 7'h10);
    short_detect <= 1'h0;
    repeat (20) @(posedge pclk);
    check(32'(obs[4]), 32'h1);
    go(1'h0, 1'h0);
    n = 0;
    while (obs[5] !== 1'h1)
    begin
      @(posedge pclk);
      n++;
      limit(n);
    end
    check(32'(n >= STBY && n <= STBY + 10), 32'h1);
    apb(1'h0, STATUS_ADDR, '0);
    check(rd, 32'h9C0);
    go(1'h1, 1'h0);
    wait_obs(7'h3F, 7'h09);
    wait_obs(7'h40, 7'h40);
    finish_test();
  end
endmodule
